// >>> nrt_core.sv
// Executor for the data-movement instruction group of a 4-bit CPU core.
// Overview of operation
// - Swap accumulator with RAM nibble at the data pointer.
// - Swap also sets X to X xor the immediate nibble.
// - Swap also increments Y modulo sixteen; carry flag untouched.
// - Skip next instruction when incremented Y is zero.
// - Load E: upper nibble from B, lower from accumulator.
// - Unload E: upper nibble to B, lower to accumulator.
// - Direction gets acc bits 2..0; reverse clears acc bit 3.
// - One-cycle moves between accumulator and B, and accumulator and Y.
`timescale 1ns/1ps
module nrt_core (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       instr_valid,
  input  wire logic [nrt_pkg::OPC_W-1:0]  instr,
  input  wire logic [nrt_pkg::NIB_W-1:0]  mem_rdata,
  output logic      [nrt_pkg::NIB_W-1:0]  mem_wdata,
  output logic                            mem_we,
  output logic      [nrt_pkg::NIB_W-1:0]  acc,
  output logic      [nrt_pkg::NIB_W-1:0]  reg_b,
  output logic      [nrt_pkg::NIB_W-1:0]  reg_x,
  output logic      [nrt_pkg::NIB_W-1:0]  reg_y,
  output logic      [nrt_pkg::E_W-1:0]    reg_e,
  output logic      [nrt_pkg::DIR_W-1:0]  direction_register,
  output logic                            skip_next,
  output logic                            op_done
);

  // ---------------------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n_q;

  // Asynchronous assert, synchronous release through two stages.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q   <= 1'h0;
      rst_sync_n_q <= 1'h0;
    end else begin
      rst_meta_q   <= 1'h1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  nrt_pkg::nrt_op_t op;
  logic [nrt_pkg::NIB_W-1:0] imm;

  nrt_decode u_decode (
    .opcode (instr),
    .op     (op)
  );

  assign imm = instr[nrt_pkg::NIB_W-1:0];

  // ---------------------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------------------
  logic [nrt_pkg::NIB_W-1:0] acc_q,  acc_d;
  logic [nrt_pkg::NIB_W-1:0] b_q,    b_d;
  logic [nrt_pkg::NIB_W-1:0] x_q,    x_d;
  logic [nrt_pkg::NIB_W-1:0] y_q,    y_d;
  logic [nrt_pkg::E_W-1:0]   e_q,    e_d;
  logic [nrt_pkg::DIR_W-1:0] dir_q,  dir_d;
  logic [nrt_pkg::NIB_W-1:0] wdat_q, wdat_d;
  logic                      we_q,   we_d;
  logic                      skip_q, skip_d;
  logic                      done_q, done_d;
  logic [nrt_pkg::NIB_W-1:0] y_inc;

  // The carry flag lives elsewhere; nothing here can disturb it.
  assign y_inc = y_q + nrt_pkg::NIB_ONE;

  // ---------------------------------------------------------------------------
  // Register file next state
  // ---------------------------------------------------------------------------
  // An unrecognised or absent instruction holds every register. Each case arm
  // writes only the registers that its operation names, so a stray decode can
  // never disturb a register that the instruction does not mention.
  always_comb begin
    acc_d = acc_q;
    b_d   = b_q;
    x_d   = x_q;
    y_d   = y_q;
    e_d   = e_q;
    dir_d = dir_q;
    if (instr_valid) begin
      unique case (op)
        nrt_pkg::NRT_OP_SWAP: begin
          // The memory side of the swap is formed in the pulse group below.
          // swap with memory
          acc_d = mem_rdata;
          x_d   = x_q ^ imm;
          y_d   = y_inc;
        end
        nrt_pkg::NRT_OP_B_ACC: begin
          acc_d = b_q;
        end
        nrt_pkg::NRT_OP_ACC_B: begin
          b_d = acc_q;
        end
        nrt_pkg::NRT_OP_Y_ACC: begin
          acc_d = y_q;
        end
        nrt_pkg::NRT_OP_ACC_Y: begin
          y_d = acc_q;
        end
        nrt_pkg::NRT_OP_LOAD_E: begin
          e_d = {b_q, acc_q};  // B lands in the upper nibble.
        end
        nrt_pkg::NRT_OP_UNLD_E: begin
          b_d   = e_q[nrt_pkg::E_W-1:nrt_pkg::NIB_W];
          acc_d = e_q[nrt_pkg::NIB_W-1:0];
        end
        nrt_pkg::NRT_OP_A_DIR: begin
          dir_d = acc_q[nrt_pkg::DIR_W-1:0];  // Accumulator bit 3 has nowhere to go and is dropped.
        end
        nrt_pkg::NRT_OP_DIR_A: begin
          acc_d = {1'h0, dir_q};  // Bit 3 is cleared, never left stale.
        end
        // Unknown opcodes fall here and change nothing.
        nrt_pkg::NRT_OP_NONE: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Register file flip-flops
  // ---------------------------------------------------------------------------
  // Cleared from the synchronised reset so that every register leaves reset on
  // the same edge; one instruction per clock, no stalls.
  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      acc_q <= nrt_pkg::NIB_ZERO;
      b_q   <= nrt_pkg::NIB_ZERO;
      x_q   <= nrt_pkg::NIB_ZERO;
      y_q   <= nrt_pkg::NIB_ZERO;
      e_q   <= nrt_pkg::E_ZERO;
      dir_q <= nrt_pkg::DIR_ZERO;
    end else begin
      acc_q <= acc_d;
      b_q   <= b_d;
      x_q   <= x_d;
      y_q   <= y_d;
      e_q   <= e_d;
      dir_q <= dir_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Memory write-back and completion pulses
  // ---------------------------------------------------------------------------
  // The pulses last one cycle. The write data keeps its old value between swaps,
  // which saves toggling on the RAM data lines at the cost of one more register.
  // Skip is worked out from the incremented Y, not the registered one.
  always_comb begin
    wdat_d = wdat_q;
    we_d   = 1'h0;
    skip_d = 1'h0;
    done_d = 1'h0;
    if (instr_valid) begin
      done_d = (op != nrt_pkg::NRT_OP_NONE);
      if (op == nrt_pkg::NRT_OP_SWAP) begin
        wdat_d = acc_q;
        we_d   = 1'h1;
        skip_d = (y_inc == nrt_pkg::NIB_ZERO);
      end
    end
  end

  // Pulse flip-flops. The write is one cycle behind the swap, so the data pointer
  // must still address the same nibble in the cycle after a swap.
  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      wdat_q <= nrt_pkg::NIB_ZERO;
      we_q   <= 1'h0;
      skip_q <= 1'h0;
      done_q <= 1'h0;
    end else begin
      wdat_q <= wdat_d;
      we_q   <= we_d;
      skip_q <= skip_d;
      done_q <= done_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------------------
  assign acc                = acc_q;
  assign reg_b              = b_q;
  assign reg_x              = x_q;
  assign reg_y              = y_q;
  assign reg_e              = e_q;
  assign direction_register = dir_q;
  assign mem_wdata          = wdat_q;
  assign mem_we             = we_q;   // Write lands one cycle late; the pointer must hold meanwhile.
  assign skip_next          = skip_q;
  assign op_done            = done_q;

endmodule : nrt_core

// >>> nrt_core_properties.sv
// Port-level assertions for the nibble register transfer executor.
`timescale 1ns/1ps
module nrt_core_check (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       instr_valid,
  input wire logic [9:0] instr,
  input wire logic [3:0] mem_rdata,
  input wire logic [3:0] mem_wdata,
  input wire logic       mem_we,
  input wire logic [3:0] acc,
  input wire logic [3:0] reg_b,
  input wire logic [3:0] reg_x,
  input wire logic [3:0] reg_y,
  input wire logic [7:0] reg_e,
  input wire logic [2:0] direction_register,
  input wire logic       skip_next,
  input wire logic       op_done
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // A swap matches on the upper six bits whatever the immediate is.
  wire logic sw        = instr_valid && instr[9:4] == nrt_pkg::OPC_SWAP_HI;
  // One strobe per exact opcode, so that the properties read sampled nets only.
  wire logic hit_b_acc = instr_valid && instr == nrt_pkg::OPC_MOVE_B_ACC;
  wire logic hit_acc_b = instr_valid && instr == nrt_pkg::OPC_ACC_TO_B;
  wire logic hit_y_acc = instr_valid && instr == nrt_pkg::OPC_Y_TO_ACC;
  wire logic hit_acc_y = instr_valid && instr == nrt_pkg::OPC_ACC_TO_Y;
  wire logic hit_ld_e  = instr_valid && instr == nrt_pkg::OPC_LOAD_E;
  wire logic hit_ul_e  = instr_valid && instr == nrt_pkg::OPC_UNLOAD_E;
  wire logic hit_a_dir = instr_valid && instr == nrt_pkg::OPC_ACC_TO_DIR;
  wire logic hit_dir_a = instr_valid && instr == nrt_pkg::OPC_DIR_TO_ACC;
  wire logic known     = sw || hit_b_acc || hit_acc_b || hit_y_acc || hit_acc_y || hit_ld_e || hit_ul_e
                         || hit_a_dir || hit_dir_a;
  sequence s_swap;
    sw;
  endsequence
  sequence s_swap_done;
    op_done && mem_we;
  endsequence
  // Old accumulator goes to RAM, the RAM nibble comes into the accumulator.
  sequence s_swap_data;
    acc == $past(mem_rdata) && mem_wdata == $past(acc);
  endsequence
  // Nothing moves and no pulse fires.
  sequence s_quiet;
    !op_done && !mem_we && !skip_next && $stable(acc) && $stable(reg_b) && $stable(reg_x) && $stable(reg_y)
      && $stable(reg_e) && $stable(direction_register);
  endsequence
  a_swap_exchange: assert property (s_swap |=> s_swap_done ##0 s_swap_data)
    else $error("swap exchange wrong");
  a_x_xor: assert property (s_swap |=> reg_x == ($past(reg_x) ^ $past(instr[3:0])))
    else $error("x update wrong");
  a_y_incr: assert property (s_swap |=> reg_y == $past(reg_y) + 4'h1)
    else $error("y increment wrong");
  a_skip_zero: assert property (s_swap |=> skip_next == (reg_y == 4'h0))
    else $error("skip wrong");
  a_skip_only: assert property (!sw |=> !skip_next && !mem_we)
    else $error("stray pulse");
  // E loads from B and acc
  a_load_e: assert property (hit_ld_e |=> reg_e == {$past(reg_b), $past(acc)})
    else $error("load e wrong");
  // E unloads into B and acc
  a_unload_e: assert property (hit_ul_e |=> {reg_b, acc} == $past(reg_e))
    else $error("unload e wrong");
  a_dir_moves: assert property ((hit_a_dir |=> direction_register == $past(acc[2:0])) and
    (hit_dir_a |=> acc == {1'h0, $past(direction_register)}))
    else $error("direction move wrong");
  // moves among acc, B and Y
  a_reg_moves: assert property ((hit_b_acc |=> acc == $past(reg_b)) and (hit_acc_b |=> reg_b == $past(acc)) and
    (hit_y_acc |=> acc == $past(reg_y)) and (hit_acc_y |=> reg_y == $past(acc)))
    else $error("register move wrong");
  a_refused_quiet: assert property (!instr_valid |=> s_quiet)
    else $error("idle cycle changed state");
  a_unknown_quiet: assert property (instr_valid && !known |=> s_quiet)
    else $error("unknown opcode changed state");
endmodule : nrt_core_check
bind nrt_core nrt_core_check u_chk (
  .clk                (clk),
  .rst_n              (rst_n),
  .instr_valid        (instr_valid),
  .instr              (instr),
  .mem_rdata          (mem_rdata),
  .mem_wdata          (mem_wdata),
  .mem_we             (mem_we),
  .acc                (acc),
  .reg_b              (reg_b),
  .reg_x              (reg_x),
  .reg_y              (reg_y),
  .reg_e              (reg_e),
  .direction_register (direction_register),
  .skip_next          (skip_next),
  .op_done            (op_done)
);

// >>> nrt_decode.sv
// Opcode decoder for the nibble register transfer executor.
`timescale 1ns/1ps
module nrt_decode (
  input  wire logic [nrt_pkg::OPC_W-1:0] opcode,
  output nrt_pkg::nrt_op_t               op
);

  always_comb begin
    if (opcode[nrt_pkg::OPC_W-1:nrt_pkg::NIB_W] == nrt_pkg::OPC_SWAP_HI) begin
      op = nrt_pkg::NRT_OP_SWAP;
    end else begin
      unique case (opcode)
        nrt_pkg::OPC_MOVE_B_ACC: op = nrt_pkg::NRT_OP_B_ACC;
        nrt_pkg::OPC_ACC_TO_B:   op = nrt_pkg::NRT_OP_ACC_B;
        nrt_pkg::OPC_Y_TO_ACC:   op = nrt_pkg::NRT_OP_Y_ACC;
        nrt_pkg::OPC_ACC_TO_Y:   op = nrt_pkg::NRT_OP_ACC_Y;
        nrt_pkg::OPC_LOAD_E:     op = nrt_pkg::NRT_OP_LOAD_E;
        nrt_pkg::OPC_UNLOAD_E:   op = nrt_pkg::NRT_OP_UNLD_E;
        nrt_pkg::OPC_ACC_TO_DIR: op = nrt_pkg::NRT_OP_A_DIR;
        nrt_pkg::OPC_DIR_TO_ACC: op = nrt_pkg::NRT_OP_DIR_A;
        default:                 op = nrt_pkg::NRT_OP_NONE;
      endcase
    end
  end

endmodule : nrt_decode

// >>> nrt_pkg.sv
// Opcode patterns and widths for the nibble register transfer executor.
package nrt_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned OPC_W  = 10;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned E_W    = 8;
  localparam int unsigned DIR_W  = 3;
  localparam int unsigned ADDR_W = 9;

  // ---------------------------------------------------------------------------
  // Opcodes (swap opcode carries the immediate in bits 3..0)
  // ---------------------------------------------------------------------------
  localparam logic [5:0]       OPC_SWAP_HI      = 6'h2E;
  localparam logic [OPC_W-1:0] OPC_MOVE_B_ACC   = 10'h01E;
  localparam logic [OPC_W-1:0] OPC_ACC_TO_B     = 10'h00E;
  localparam logic [OPC_W-1:0] OPC_Y_TO_ACC     = 10'h01F;
  localparam logic [OPC_W-1:0] OPC_ACC_TO_Y     = 10'h00C;
  localparam logic [OPC_W-1:0] OPC_LOAD_E       = 10'h01A;
  localparam logic [OPC_W-1:0] OPC_UNLOAD_E     = 10'h02A;
  localparam logic [OPC_W-1:0] OPC_ACC_TO_DIR   = 10'h029;
  localparam logic [OPC_W-1:0] OPC_DIR_TO_ACC   = 10'h051;

  // ---------------------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------------------
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic [NIB_W-1:0] NIB_ONE  = 4'h1;
  localparam logic [E_W-1:0]   E_ZERO   = 8'h00;
  localparam logic [DIR_W-1:0] DIR_ZERO = 3'h0;

  typedef enum logic [3:0] {
    NRT_OP_NONE    = 4'h0,
    NRT_OP_SWAP    = 4'h1,
    NRT_OP_B_ACC   = 4'h2,
    NRT_OP_ACC_B   = 4'h3,
    NRT_OP_Y_ACC   = 4'h4,
    NRT_OP_ACC_Y   = 4'h5,
    NRT_OP_LOAD_E  = 4'h6,
    NRT_OP_UNLD_E  = 4'h7,
    NRT_OP_A_DIR   = 4'h8,
    NRT_OP_DIR_A   = 4'h9
  } nrt_op_t;

endpackage : nrt_pkg

// >>> testbench.sv
// Self-checking random bench for the nibble register transfer executor.
`timescale 1ns/1ps
module testbench;
  // ------------------
  // Signals and model
  // ------------------
  logic        clk, rst_n, instr_valid, mem_we, skip_next, op_done, we, sk;
  logic [9:0]  instr;
  logic [3:0]  mem_rdata, mem_wdata, acc, reg_b, reg_x, reg_y, ma, mb, mx, my, j, wd;
  logic [7:0]  reg_e, me;
  logic [2:0]  direction_register, md;
  logic [32:0] exp_q[$];
  logic [9:0]  opc[1:8] = '{nrt_pkg::OPC_MOVE_B_ACC, nrt_pkg::OPC_ACC_TO_B, nrt_pkg::OPC_Y_TO_ACC,
    nrt_pkg::OPC_ACC_TO_Y, nrt_pkg::OPC_LOAD_E, nrt_pkg::OPC_UNLOAD_E, nrt_pkg::OPC_ACC_TO_DIR, nrt_pkg::OPC_DIR_TO_ACC};
  int          fails, checks_done, sel;
  nrt_core DUT (.clk, .rst_n, .instr_valid, .instr, .mem_rdata, .mem_wdata, .mem_we, .acc, .reg_b, .reg_x,
    .reg_y, .reg_e, .direction_register, .skip_next, .op_done);
  // Write data only matters while the write pulse is up, so it is masked otherwise.
  wire logic [32:0] seen = {mem_we, skip_next, mem_we ? mem_wdata : 4'h0, acc, reg_b, reg_x, reg_y, reg_e,
    direction_register};
  task automatic cmp(string what, logic [32:0] e, logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Each completion pulse retires the oldest note; an empty queue means a spurious pulse.
  always @(negedge clk) begin
    if (op_done === 1'h1) begin
      if (exp_q.size() == 0)
        cmp("spurious done", 'x, seen);
      else
        cmp("state", exp_q.pop_front(), seen);
    end
  end
  // Watchdog sized well past the expected run of about 3020 cycles.
  initial begin
    #40000;
    fails++;
    report_and_stop();
  end
  // Random ops back to back, with idle and unknown opcodes mixed in.
  initial begin
    void'($urandom(32'h849359C0));
    {rst_n, instr_valid, instr, mem_rdata, ma, mb, mx, my, me, md} = '0;
    repeat (16) @(negedge clk);
    cmp("reset state", 33'h0, seen);
    rst_n = 1'h1;
    repeat (3) @(negedge clk);
    $display("test reset done");
    repeat (3000) begin
      sel = $urandom_range(10);
      j = 4'($urandom);
      mem_rdata = 4'($urandom);
      instr_valid = (sel != 10);
      instr = (sel == 0) ? {nrt_pkg::OPC_SWAP_HI, j} : (sel < 9) ? opc[sel] : 10'h3FF;
      {we, sk, wd} = '0;
      case (sel)
        0: begin
          we = 1'h1;
          wd = ma;
          ma = mem_rdata;
          mx = mx ^ j;
          my = my + 4'h1;
          sk = (my == 4'h0);
        end
        1: ma = mb;
        2: mb = ma;
        3: ma = my;
        4: my = ma;
        5: me = {mb, ma};
        6: {mb, ma} = me;
        7: md = ma[2:0];
        8: ma = {1'b0, md};
        default: ;
      endcase
      if (sel < 9)
        exp_q.push_back({we, sk, wd, ma, mb, mx, my, me, md});
      @(negedge clk);
    end
    instr_valid = 1'h0;
    repeat (2) @(negedge clk);
    cmp("pending notes", 33'h0, 33'(exp_q.size()));
    $display("test random done");
    report_and_stop();
  end
endmodule : testbench
